// ===== ccrm_map.svh
// constants for the converter configuration register bank: offsets, fields, resets, word lengths
// assumes inclusion by bare name from the ccrm_outfmt and ccrm_top modules of this block
//
// Overview of operation
// - host drives serial clock and select; device only samples them as inputs
// - data pin is input during write data, driven by device during readback
// - bit-order bits 6 and 1 of 0x00: 0 msb first, 1 lsb first
// - soft-reset bits 5 and 2 restore defaults except 0x00, 0x09, 0x0A
// - grade register reports speed grade in bits [5:4], zero means 10 MHz grade
// - power field: 0 normal, 1 local down, 2 standby, 3 sleep
// - bit 2 of 0x09 enables the multiplier loop, reset value off
// - bit 7 of 0x0A reads 1 when the multiplier loop is locked
// - 0x0A bit 6 auto band, bits [5:0] multiplier factor, default 0
// - 0x0F bits [6:5]: 10 MHz for 0 and 3, 5 for 1, 2.5 for 2
// - format: offset binary for 0 and 3, twos complement 1, gray 2
// - output-disable bit floats all parallel data outputs
// - output-invert bit inverts every parallel output bit
// - interleave bit puts both channels on the single 16-bit bus
// - 0x16 bit 7 inverts data clock output polarity, default uninverted
// - 0x101 six-bit rate code selects output data rate, default 0
// - 0x111 bit 7 enables overrange self-clear, driven on overrange_self_clear_out, not on the overrange pin
// - 0x111 bit 6 indicator mode, bits [5:0] threshold, all default 0
// - access starts with 16-bit instruction, then 8-bit words until select rises; length bits ignored
// - select low gates a cycle; activity ignored while select high
// - read flag is the first instruction bit msb first, the last lsb first; pin turns to output for read data
`ifndef CCRM_MAP_SVH
`define CCRM_MAP_SVH
`define CCRM_ADDR_CFG 13'h0000
`define CCRM_ADDR_ID 13'h0001
`define CCRM_ADDR_GRADE 13'h0002
`define CCRM_ADDR_PWR 13'h0008
`define CCRM_ADDR_LOOPEN 13'h0009
`define CCRM_ADDR_LOOP 13'h000A
`define CCRM_ADDR_BW 13'h000F
`define CCRM_ADDR_OMODE 13'h0014
`define CCRM_ADDR_ODRV 13'h0015
`define CCRM_ADDR_OCLK 13'h0016
`define CCRM_ADDR_REF 13'h0018
`define CCRM_ADDR_RATE 13'h0101
`define CCRM_ADDR_OVR 13'h0111
`define CCRM_CFG_FIXED 8'h18
`define CCRM_RST_ODRV 8'h02
`define CCRM_RST_ZERO 8'h00
`define CCRM_BIT_LSB_HI 6
`define CCRM_BIT_LSB_LO 1
`define CCRM_BIT_SRST_HI 5
`define CCRM_BIT_SRST_LO 2
`define CCRM_BIT_LOOPEN 2
`define CCRM_BIT_LOCK 7
`define CCRM_BIT_AUTOBAND 6
`define CCRM_BIT_DATA_CLOCK_OUT_INVERT 7
`define CCRM_BIT_SELFCLR 7
`define CCRM_BIT_ORMODE 6
`define CCRM_BIT_IL 5
`define CCRM_BIT_FLOAT 4
`define CCRM_BIT_INV 2
`define CCRM_GRADE_LSB 4
`define CCRM_BW_LSB 5
`define CCRM_INSTR_BITS 16
`define CCRM_WORD_BITS 8
`endif

// ===== ccrm_pkg.sv
// types shared by the converter configuration register bank
// assumes ccrm_map.svh alongside for numeric constants
`default_nettype none
package ccrm_pkg;
    typedef enum logic [1:0] {
        CCRM_PWR_NORMAL,
        CCRM_PWR_LOCAL_DOWN,
        CCRM_PWR_STANDBY,
        CCRM_PWR_SLEEP
    } ccrm_power_e;
    typedef enum logic [1:0] {
        CCRM_FMT_OFFSET,
        CCRM_FMT_TWOS,
        CCRM_FMT_GRAY,
        CCRM_FMT_OFFSET_ALT
    } ccrm_format_e;
    typedef enum logic [1:0] {
        CCRM_BW_10M,
        CCRM_BW_5M,
        CCRM_BW_2M5,
        CCRM_BW_10M_ALT
    } ccrm_band_e;
    typedef enum logic [1:0] {
        CCRM_PH_IDLE,
        CCRM_PH_INSTR,
        CCRM_PH_DATA
    } ccrm_phase_e;
endpackage : ccrm_pkg
`default_nettype wire

// ===== ccrm_sync.sv
// two-flop synchroniser for one pin level
// assumes the input is asynchronous to clk_sys_in
`default_nettype none
module ccrm_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic clk_sys_in, // system clock
    input wire logic reset_in, // synchronous reset, active high
    input wire logic async_in, // pin level
    output logic sync_out // synchronised level
);
    logic meta_q;
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            meta_q <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // ccrm_sync
`default_nettype wire

// ===== ccrm_outfmt.sv
// parallel output word formatting: code conversion, inversion, float, interleave
// assumes samples arrive on the system clock with a valid strobe
`include "ccrm_map.svh"
`default_nettype none
module ccrm_outfmt #(
    parameter int WIDTH = 16
) (
    input wire logic clk_sys_in, // system clock
    input wire logic reset_in, // synchronous reset
    input wire logic [WIDTH-1:0] sample_a_in, // channel a, offset binary
    input wire logic [WIDTH-1:0] sample_b_in, // channel b, offset binary
    input wire logic sample_valid_in, // new sample pair
    input wire logic [7:0] omode_in, // output modes register
    output logic [WIDTH-1:0] data_out, // parallel word
    output logic [WIDTH-1:0] data_oe_out // per-bit drive enable
);
    logic [WIDTH-1:0] word_d;
    logic sel_b_q;
    function automatic logic [WIDTH-1:0] fmt(input logic [WIDTH-1:0] s, input logic [1:0] f);
        case (ccrm_pkg::ccrm_format_e'(f))
            ccrm_pkg::CCRM_FMT_TWOS: return {~s[WIDTH-1], s[WIDTH-2:0]};
            ccrm_pkg::CCRM_FMT_GRAY: return s ^ (s >> 1);
            default: return s;
        endcase
    endfunction
    always_comb begin
        // interleave alternates channels on consecutive samples of the one bus
        if (omode_in[`CCRM_BIT_IL] && sel_b_q) begin
            word_d = fmt(sample_b_in, omode_in[1:0]);
        end else begin
            word_d = fmt(sample_a_in, omode_in[1:0]);
        end
        if (omode_in[`CCRM_BIT_INV]) begin
            word_d = ~word_d;
        end
    end
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            sel_b_q <= 1'b0;
        end else if (sample_valid_in) begin
            sel_b_q <= omode_in[`CCRM_BIT_IL] ? ~sel_b_q : 1'b0;
        end
    end
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            data_out <= '0;
            data_oe_out <= '0;
        end else begin
            if (sample_valid_in) begin
                data_out <= word_d;
            end
            data_oe_out <= {WIDTH{~omode_in[`CCRM_BIT_FLOAT]}};
        end
    end
endmodule // ccrm_outfmt
`default_nettype wire

// ===== ccrm_top.sv
// serial-port register bank of the converter with its control outputs
// assumes host is serial master; the serial clock is sampled by clk_sys_in (>= 4x faster)
`include "ccrm_map.svh"
`default_nettype none
module ccrm_top #(
    parameter logic [7:0] PART_CODE = 8'hA5, // arbitrary neutral identification value
    parameter logic [1:0] SPEED_GRADE = 2'h0,
    parameter int WIDTH = 16
) (
    input wire logic clk_sys_in, // system clock, 50 MHz
    input wire logic reset_in, // synchronous reset, active high
    input wire logic sclk_in, // serial clock pin from host
    input wire logic select_n_in, // serial select pin, active low
    input wire logic sdio_in, // serial data pin level
    output logic sdio_out, // serial data drive value
    output logic sdio_oe_out, // serial data drive enable, high drives
    input wire logic loop_lock_in, // multiplier loop lock, asynchronous
    input wire logic overrange_in, // overrange event from datapath, same clock
    input wire logic [WIDTH-1:0] sample_a_in, // channel a sample
    input wire logic [WIDTH-1:0] sample_b_in, // channel b sample
    input wire logic sample_valid_in, // sample strobe
    output logic [WIDTH-1:0] data_out, // parallel data
    output logic [WIDTH-1:0] data_oe_out, // parallel data drive enable
    input wire logic data_clock_in, // internal data clock
    output logic data_clock_out_out, // data clock output pin
    output logic overrange_out, // overrange pin
    output logic [1:0] power_state_select_out, // power state
    output logic multiplier_loop_on_out, // loop enable
    output logic auto_band_select_out, // loop auto band
    output logic [5:0] loop_multiplier_out, // loop factor
    output logic [1:0] passband_select_out, // bandwidth code
    output logic [5:0] output_rate_out, // rate code
    output logic overrange_self_clear_out, // self-clear enable
    output logic overrange_indicator_mode_out, // indicator mode
    output logic [5:0] overrange_level_out, // overrange threshold
    output logic output_level_standard_out, // output drive standard
    output logic [3:0] output_drive_out, // drive strength fields
    output logic external_reference_out // external reference select
);
    logic sclk_s, sel_n_s, sdio_s, lock_s;
    logic sclk_prev_q;
    ccrm_pkg::ccrm_phase_e phase_q;
    logic [15:0] instr_q;
    logic [4:0] bit_cnt_q;
    logic [7:0] shift_q, rd_q;
    logic [12:0] addr_q;
    logic is_read_q;
    logic low_bit_first_select_q;
    logic [7:0] pwr_q, loopen_q, loop_q, bw_q, omode_q, odrv_q, oclk_q, ref_q, rate_q, ovr_q;
    logic sclk_rise, sclk_fall, wr_stb;
    logic [7:0] wr_byte, rd_byte;
    logic soft_reset;
    logic [15:0] instr_w, instr_lsb;
    logic [3:0] pins_s;
    wire [3:0] pins_w = {loop_lock_in, sdio_in, select_n_in, sclk_in};

    // all four pin inputs (serial clock, select, data, loop lock) are synchronised before use
    for (genvar g = 0; g < 4; g++) begin : g_sync
        ccrm_sync #(.RESET_VALUE(g == 1)) u_sync (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
            .async_in(pins_w[g]), .sync_out(pins_s[g]));
    end
    assign {lock_s, sdio_s, sel_n_s, sclk_s} = pins_s;

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
        end
    end
    assign sclk_rise = sclk_s & ~sclk_prev_q & ~sel_n_s;
    assign sclk_fall = ~sclk_s & sclk_prev_q & ~sel_n_s;

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction

    // shift register always fills msb first; lsb-first words are reversed at use
    assign wr_byte = low_bit_first_select_q ? rev8({shift_q[6:0], sdio_s})
                                            : {shift_q[6:0], sdio_s};
    assign instr_w = {instr_q[14:0], sdio_s};
    assign instr_lsb = {rev8(instr_w[7:0]), rev8(instr_w[15:8])};
    assign wr_stb = sclk_rise && (phase_q == ccrm_pkg::CCRM_PH_DATA) && !is_read_q
                    && (bit_cnt_q == 5'd7);
    assign soft_reset = wr_stb && (addr_q == `CCRM_ADDR_CFG)
                        && (wr_byte[`CCRM_BIT_SRST_HI] || wr_byte[`CCRM_BIT_SRST_LO]);

    always_ff @(posedge clk_sys_in) begin
        if (reset_in || sel_n_s) begin
            phase_q <= ccrm_pkg::CCRM_PH_INSTR;
            bit_cnt_q <= '0;
            shift_q <= '0;
            instr_q <= '0;
            addr_q <= '0;
            is_read_q <= 1'b0;
        end else if (sclk_rise) begin
            shift_q <= {shift_q[6:0], sdio_s};
            case (phase_q)
                ccrm_pkg::CCRM_PH_INSTR: begin
                    instr_q <= {instr_q[14:0], sdio_s};
                    if (bit_cnt_q == 5'(`CCRM_INSTR_BITS - 1)) begin
                        phase_q <= ccrm_pkg::CCRM_PH_DATA;
                        bit_cnt_q <= '0;
                        // lsb-first instructions carry address first and the read flag last
                        if (low_bit_first_select_q) begin
                            addr_q <= instr_lsb[12:0];
                            is_read_q <= instr_lsb[15];
                        end else begin
                            addr_q <= {instr_q[11:0], sdio_s};
                            is_read_q <= instr_q[14];
                        end
                    end else begin
                        bit_cnt_q <= bit_cnt_q + 5'd1;
                    end
                end
                ccrm_pkg::CCRM_PH_DATA: begin
                    if (bit_cnt_q == 5'(`CCRM_WORD_BITS - 1)) begin
                        bit_cnt_q <= '0;
                        // streaming walks the address, down for msb first, up for lsb first
                        addr_q <= low_bit_first_select_q ? addr_q + 13'd1 : addr_q - 13'd1;
                    end else begin
                        bit_cnt_q <= bit_cnt_q + 5'd1;
                    end
                end
                default: phase_q <= ccrm_pkg::CCRM_PH_INSTR;
            endcase
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        if (addr_q == `CCRM_ADDR_CFG) begin
            rd_byte = `CCRM_CFG_FIXED;
            rd_byte[`CCRM_BIT_LSB_HI] = low_bit_first_select_q;
            rd_byte[`CCRM_BIT_LSB_LO] = low_bit_first_select_q;
        end else if (addr_q == `CCRM_ADDR_ID) begin
            rd_byte = PART_CODE;
        end else if (addr_q == `CCRM_ADDR_GRADE) begin
            rd_byte = {2'b00, SPEED_GRADE, 4'h0};
        end else if (addr_q == `CCRM_ADDR_PWR) begin
            rd_byte = pwr_q;
        end else if (addr_q == `CCRM_ADDR_LOOPEN) begin
            rd_byte = loopen_q;
        end else if (addr_q == `CCRM_ADDR_LOOP) begin
            rd_byte = {lock_s, loop_q[6:0]};
        end else if (addr_q == `CCRM_ADDR_BW) begin
            rd_byte = bw_q;
        end else if (addr_q == `CCRM_ADDR_OMODE) begin
            rd_byte = omode_q;
        end else if (addr_q == `CCRM_ADDR_ODRV) begin
            rd_byte = odrv_q;
        end else if (addr_q == `CCRM_ADDR_OCLK) begin
            rd_byte = oclk_q;
        end else if (addr_q == `CCRM_ADDR_REF) begin
            rd_byte = ref_q;
        end else if (addr_q == `CCRM_ADDR_RATE) begin
            rd_byte = rate_q;
        end else if (addr_q == `CCRM_ADDR_OVR) begin
            rd_byte = ovr_q;
        end
    end

    // readback drive: pin turns on the sclk falling edge after the instruction
    always_ff @(posedge clk_sys_in) begin
        if (reset_in || sel_n_s) begin
            sdio_oe_out <= 1'b0;
            sdio_out <= 1'b0;
            rd_q <= '0;
        end else if (sclk_fall && phase_q == ccrm_pkg::CCRM_PH_DATA && is_read_q) begin
            sdio_oe_out <= 1'b1;
            if (bit_cnt_q == 5'd0) begin
                rd_q <= low_bit_first_select_q ? {1'b0, rd_byte[7:1]} : {rd_byte[6:0], 1'b0};
                sdio_out <= low_bit_first_select_q ? rd_byte[0] : rd_byte[7];
            end else begin
                rd_q <= low_bit_first_select_q ? {1'b0, rd_q[7:1]} : {rd_q[6:0], 1'b0};
                sdio_out <= low_bit_first_select_q ? rd_q[0] : rd_q[7];
            end
        end
    end

    // port configuration survives soft reset
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            low_bit_first_select_q <= 1'b0;
        end else if (wr_stb && addr_q == `CCRM_ADDR_CFG) begin
            low_bit_first_select_q <= wr_byte[`CCRM_BIT_LSB_HI] | wr_byte[`CCRM_BIT_LSB_LO];
        end
    end

    // loop registers survive soft reset
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            loopen_q <= `CCRM_RST_ZERO;
            loop_q <= `CCRM_RST_ZERO;
        end else if (wr_stb && addr_q == `CCRM_ADDR_LOOPEN) begin
            loopen_q <= {5'h00, wr_byte[`CCRM_BIT_LOOPEN], 2'b00};
        end else if (wr_stb && addr_q == `CCRM_ADDR_LOOP) begin
            loop_q <= {1'b0, wr_byte[6:0]};
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in || soft_reset) begin
            pwr_q <= `CCRM_RST_ZERO;
            bw_q <= `CCRM_RST_ZERO;
            omode_q <= `CCRM_RST_ZERO;
            odrv_q <= `CCRM_RST_ODRV;
            oclk_q <= `CCRM_RST_ZERO;
            ref_q <= `CCRM_RST_ZERO;
            rate_q <= `CCRM_RST_ZERO;
            ovr_q <= `CCRM_RST_ZERO;
        end else if (wr_stb) begin
            // id and grade have no storage, so writes there fall away
            if (addr_q == `CCRM_ADDR_PWR) begin
                pwr_q <= {6'h00, wr_byte[1:0]};
            end else if (addr_q == `CCRM_ADDR_BW) begin
                bw_q <= {1'b0, wr_byte[6:5], 5'h00};
            end else if (addr_q == `CCRM_ADDR_OMODE) begin
                omode_q <= {wr_byte[7], 1'b0, wr_byte[5:4], 1'b0, wr_byte[2:0]};
            end else if (addr_q == `CCRM_ADDR_ODRV) begin
                odrv_q <= {4'h0, wr_byte[3:0]};
            end else if (addr_q == `CCRM_ADDR_OCLK) begin
                oclk_q <= {wr_byte[7], 7'h00};
            end else if (addr_q == `CCRM_ADDR_REF) begin
                ref_q <= {1'b0, wr_byte[6], 6'h00};
            end else if (addr_q == `CCRM_ADDR_RATE) begin
                rate_q <= {2'b00, wr_byte[5:0]};
            end else if (addr_q == `CCRM_ADDR_OVR) begin
                ovr_q <= wr_byte;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            power_state_select_out <= '0;
            multiplier_loop_on_out <= 1'b0;
            auto_band_select_out <= 1'b0;
            loop_multiplier_out <= '0;
            passband_select_out <= '0;
            output_rate_out <= '0;
            overrange_self_clear_out <= 1'b0;
            overrange_indicator_mode_out <= 1'b0;
            overrange_level_out <= '0;
            output_level_standard_out <= 1'b0;
            output_drive_out <= 4'h2;
            external_reference_out <= 1'b0;
            data_clock_out_out <= 1'b0;
            overrange_out <= 1'b0;
        end else begin
            power_state_select_out <= pwr_q[1:0];
            multiplier_loop_on_out <= loopen_q[`CCRM_BIT_LOOPEN];
            auto_band_select_out <= loop_q[`CCRM_BIT_AUTOBAND];
            loop_multiplier_out <= loop_q[5:0];
            passband_select_out <= bw_q[`CCRM_BW_LSB +: 2];
            output_rate_out <= rate_q[5:0];
            overrange_self_clear_out <= ovr_q[`CCRM_BIT_SELFCLR];
            overrange_indicator_mode_out <= ovr_q[`CCRM_BIT_ORMODE];
            overrange_level_out <= ovr_q[5:0];
            output_level_standard_out <= omode_q[7];
            output_drive_out <= odrv_q[3:0];
            external_reference_out <= ref_q[6];
            data_clock_out_out <= data_clock_in ^ oclk_q[`CCRM_BIT_DATA_CLOCK_OUT_INVERT];
            // the self-clear term is masked by overrange_in, so the pin only registers overrange_in
            overrange_out <= overrange_in | (ovr_q[`CCRM_BIT_SELFCLR] & overrange_out
                             & overrange_in);
        end
    end

    ccrm_outfmt #(.WIDTH(WIDTH)) u_outfmt (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .sample_a_in(sample_a_in),
        .sample_b_in(sample_b_in),
        .sample_valid_in(sample_valid_in),
        .omode_in(omode_q),
        .data_out(data_out),
        .data_oe_out(data_oe_out)
    );
endmodule // ccrm_top
`default_nettype wire

// ===== ccrm_checker.sv
// port assertions for the converter register bank
// assumes binding into ccrm_top; one clock domain, synchronous reset
`default_nettype none
module ccrm_checker #(
    parameter int WIDTH = 16
) (
    input wire logic clk_sys_in, // clock
    input wire logic reset_in, // reset
    input wire logic sclk_in, // serial clock
    input wire logic select_n_in, // select
    input wire logic sdio_out, // read bit
    input wire logic sdio_oe_out, // read enable
    input wire logic overrange_in, // event
    input wire logic overrange_out, // pin
    input wire logic data_clock_in, // data clock
    input wire logic data_clock_out_out, // data clock pin
    input wire logic [WIDTH-1:0] data_oe_out, // data enables
    input wire logic [1:0] power_state_select_out, // power
    input wire logic [5:0] output_rate_out // rate
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);
    // six idle cycles cover the two sync flops plus frame teardown
    sequence s_idle;
        select_n_in [*6];
    endsequence
    property p_oe_idle;
        s_idle |=> !sdio_oe_out;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("drive while deselected");
    property p_oe_start;
        $rose(sdio_oe_out) |-> !select_n_in;
    endproperty
    a_oe_start: assert property (p_oe_start) else $error("drive outside frame");
    property p_oe_release;
        $rose(select_n_in) |-> ##[1:8] !sdio_oe_out;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("pin not released");
    property p_shift;
        sdio_oe_out && $changed(sdio_out) |-> !$past(sclk_in, 2);
    endproperty
    a_shift: assert property (p_shift) else $error("read bit moved in high phase");
    property p_or_follow;
        1'b1 |=> overrange_out == $past(overrange_in);
    endproperty
    a_or_follow: assert property (p_or_follow) else $error("overrange pin lag");
    property p_dco;
        s_idle ##0 $changed(data_clock_in) |=> $changed(data_clock_out_out);
    endproperty
    a_dco: assert property (p_dco) else $error("data clock not passed on");
    property p_cfg_hold;
        s_idle |=> $stable(power_state_select_out) && $stable(output_rate_out);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config moved when idle");
    property p_float_all;
        data_oe_out == '0 || data_oe_out == '1;
    endproperty
    a_float_all: assert property (p_float_all) else $error("partial float");
endmodule // ccrm_checker
bind ccrm_top ccrm_checker #(.WIDTH(WIDTH)) chk (.*);
`default_nettype wire

// ===== ccrm_host.sv
// serial master model for the register bank's three-wire port
// assumes the bench calls xfer; every change lands on a falling clk_sys_in
`default_nettype none
module ccrm_host (
    input wire logic clk_sys_in, // system clock
    input wire logic dev_d_in, // device drive value
    input wire logic dev_oe_in, // device drive enable
    output logic sclk_out, // serial clock
    output logic select_n_out, // select, active low
    output logic line_out // resolved data line
);
    timeunit 1ns;
    timeprecision 1ns;
    logic h_d = 1'b0, h_oe = 1'b0, lsb = 1'b0;
    initial begin
        sclk_out = 1'b0;
        select_n_out = 1'b1;
    end
    // an undriven line shows the inverse of the last bit, so stale reads fail
    assign line_out = dev_oe_in ? dev_d_in : (h_oe ? h_d : !h_d);
    task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
                        output logic [7:0] rv);
        logic [23:0] bits;
        bits = {rd, 2'b00, a, wd};
        rv = 8'h00;
        @(negedge clk_sys_in) select_n_out = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            h_oe = !(rd && i < 8);
            h_d = !lsb ? bits[i] : (i >= 8 ? bits[31-i] : bits[7-i]);
            repeat (4) @(negedge clk_sys_in);
            sclk_out = 1'b1;
            repeat (4) @(negedge clk_sys_in);
            if (i < 8) rv[lsb ? 7-i : i] = line_out;
            sclk_out = 1'b0;
        end
        repeat (4) @(negedge clk_sys_in);
        select_n_out = 1'b1;
        h_oe = 1'b0;
        repeat (8) @(negedge clk_sys_in);
    endtask
endmodule // ccrm_host
`default_nettype wire

// ===== tb.sv
// self-checking bench for the converter register bank
// assumes ccrm_host as serial master; inputs change on falling clk_sys_in
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] PART = 8'h5C; // arbitrary identification value
    logic clk_sys_in = 1'b0, reset_in = 1'b1, loop_lock_in = 1'b0, overrange_in = 1'b0;
    logic sample_valid_in = 1'b0, data_clock_in = 1'b0, sclk_in, select_n_in, sdio_in;
    logic [15:0] sample_a_in = 16'h0, sample_b_in = 16'h0, data_out, data_oe_out;
    logic sdio_out, sdio_oe_out, data_clock_out_out, overrange_out, multiplier_loop_on_out;
    logic auto_band_select_out, overrange_self_clear_out, overrange_indicator_mode_out;
    logic output_level_standard_out, external_reference_out;
    logic [1:0] power_state_select_out, passband_select_out;
    logic [5:0] loop_multiplier_out, output_rate_out, overrange_level_out;
    logic [3:0] output_drive_out;
    int errors = 0, tests_run = 0;
    always #10 clk_sys_in = ~clk_sys_in;
    ccrm_top #(.PART_CODE(PART)) uut (.*);
    ccrm_host host (.clk_sys_in, .dev_d_in(sdio_out), .dev_oe_in(sdio_oe_out),
        .sclk_out(sclk_in), .select_n_out(select_n_in), .line_out(sdio_in));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] x;
        host.xfer(1'b0, a, d, x);
    endtask
    task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
        logic [7:0] x;
        host.xfer(1'b1, a, 8'h00, x);
        check({8'h00, x}, {8'h00, exp});
    endtask
    task automatic push(input logic [15:0] a, input logic [15:0] b);
        sample_a_in = a;
        sample_b_in = b;
        sample_valid_in = 1'b1;
        @(negedge clk_sys_in) sample_valid_in = 1'b0;
        repeat (3) @(negedge clk_sys_in);
    endtask
    task automatic t_defaults;
        rd_chk(13'h0000, 8'h18);
        rd_chk(13'h0001, PART);
        rd_chk(13'h0002, 8'h00);
        rd_chk(13'h0015, 8'h02);
        rd_chk(13'h0003, 8'h00);
        check({12'h0, output_drive_out}, 16'h0002);
        $display("defaults done");
    endtask
    task automatic t_fields;
        for (int c = 0; c < 4; c++) begin
            wr(13'h0008, 8'(c));
            check({14'h0, power_state_select_out}, 16'(c));
            wr(13'h000F, 8'(c << 5));
            check({14'h0, passband_select_out}, 16'(c));
        end
        wr(13'h0009, 8'h04);
        check({15'h0, multiplier_loop_on_out}, 16'h0001);
        wr(13'h000A, 8'hFF);
        check({9'h0, auto_band_select_out, loop_multiplier_out}, 16'h007F);
        rd_chk(13'h000A, 8'h7F);
        loop_lock_in = 1'b1;
        rd_chk(13'h000A, 8'hFF);
        wr(13'h0101, 8'h2A);
        wr(13'h0111, 8'hC5);
        check({output_rate_out, overrange_self_clear_out, overrange_indicator_mode_out,
               overrange_level_out, 2'h0}, {6'h2A, 8'hC5, 2'h0});
        wr(13'h0001, 8'h00);
        rd_chk(13'h0001, PART);
        $display("fields done");
    endtask
    task automatic t_soft_reset;
        wr(13'h0008, 8'h02);
        wr(13'h0000, 8'h3C);
        check({2'h0, output_rate_out, overrange_level_out, power_state_select_out}, 16'h0);
        check({15'h0, multiplier_loop_on_out}, 16'h0001);
        rd_chk(13'h000A, 8'hFF);
        $display("soft reset done");
    endtask
    task automatic t_bit_order;
        wr(13'h0000, 8'h5A);
        host.lsb = 1'b1;
        wr(13'h0008, 8'h01);
        check({14'h0, power_state_select_out}, 16'h0001);
        wr(13'h0000, 8'h18);
        host.lsb = 1'b0;
        wr(13'h0008, 8'h02);
        check({14'h0, power_state_select_out}, 16'h0002);
        $display("bit order done");
    endtask
    task automatic t_output;
        logic [15:0] s, exp [4];
        s = 16'h9234;
        exp = '{s, s ^ 16'h8000, s ^ (s >> 1), s};
        for (int f = 0; f < 4; f++) begin
            wr(13'h0014, 8'(f));
            push(s, 16'h0);
            check(data_out, exp[f]);
        end
        wr(13'h0014, 8'h04);
        push(s, 16'h0);
        check(data_out, ~s);
        check(data_oe_out, 16'hFFFF);
        wr(13'h0014, 8'h10);
        push(s, 16'h0);
        check(data_oe_out, 16'h0000);
        wr(13'h0014, 8'h20);
        push(16'h1111, 16'h2222);
        check(data_out, 16'h1111);
        push(16'h1111, 16'h2222);
        check(data_out, 16'h2222);
        $display("output done");
    endtask
    task automatic t_pins;
        overrange_in = 1'b1;
        @(negedge clk_sys_in) check({15'h0, overrange_out}, 16'h0001);
        overrange_in = 1'b0;
        wr(13'h0016, 8'h80);
        data_clock_in = 1'b1;
        @(negedge clk_sys_in) check({15'h0, data_clock_out_out}, 16'h0000);
        wr(13'h0016, 8'h00);
        check({15'h0, data_clock_out_out}, 16'h0001);
        $display("pins done");
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        errors++;
        complete_run();
    end
    initial begin
        repeat (2) @(negedge clk_sys_in);
        reset_in = 1'b0;
        repeat (4) @(negedge clk_sys_in);
        t_defaults();
        t_fields();
        t_soft_reset();
        t_bit_order();
        t_output();
        t_pins();
        complete_run();
    end
endmodule // tb
`default_nettype wire
